/* smc_host_model.sv */
// host model driving the spi register port in mode 0
`timescale 1ns/1ps
`default_nettype none
module smc_host_model (
	input  wire logic clk_sys,
	output logic      spi_nss_n,
	output logic      spi_sck,
	output logic      spi_mosi,
	input  wire logic spi_miso
);
	initial begin
		spi_nss_n = 1'b1;
		spi_sck = 1'b0;
		spi_mosi = 1'b0;
	end
	// ------------------------------------------------
	// one frame: header byte then one data byte
	// ------------------------------------------------
	task automatic xfer(input logic [7:0] h, input logic [7:0] d,
			output logic [7:0] q);
		logic [15:0] w;
		w = {h, d};
		@(posedge clk_sys) #1 spi_nss_n = 1'b0;
		for (int i = 15; i >= 0; i--) begin
			spi_mosi = w[i];
			repeat (6) @(posedge clk_sys);
			#1 if (i < 8) q[i] = spi_miso;
			spi_sck = 1'b1;
			repeat (6) @(posedge clk_sys);
			#1 spi_sck = 1'b0;
		end
		repeat (6) @(posedge clk_sys);
		#1 spi_nss_n = 1'b1;
		spi_mosi = ~spi_mosi;
		repeat (8) @(posedge clk_sys);
	endtask
endmodule // smc_host_model
`default_nettype wire

/* smc_modem_cfg.sv */
// spread modem configuration registers, data buffer and derived parameters
// Operation
// R1 - modem selection sits in the operating mode register and only changes while in sleep.
// R2 - in spread mode the same addresses reach a different register map than in fsk mode.
// R3 - the spread modem has its own dual-port data buffer reached over the common spi port.
// R4 - the spread factor field takes 6 to 12 and gives 2 to the power n chips per symbol.
// R5 - the host sets the same spread factor at both ends of a link.
// R6 - with spread factor 6 the host selects implicit header mode.
// R7 - with spread factor 6 the host writes 101 into bits 2 to 0 of address 0x31.
// R8 - with spread factor 6 the host writes 0x0C to address 0x37.
// R9 - the code rate field takes 1 to 4 and codes 4 data bits into 4 plus k bits.
// R10 - the code rate can travel in the packet header for per-packet decoding.
// R11 - ten channel bandwidths from 7.8 to 500 khz are selectable.
// R12 - the programmed bandwidth is the full double sideband channel width.
// R13 - the host avoids 250 and 500 khz in the 169 mhz band.
// R14 - symbol rate equals bandwidth divided by 2 to the spread factor.
// R15 - addresses 0x31 and 0x37 are full 8-bit read-write registers.
`timescale 1ns/1ps
`default_nettype none
module smc_modem_cfg #(
	parameter int FIFO_DEPTH = 64
) (
	input  wire logic        clk_sys,
	input  wire logic        rst,
	input  wire logic        spi_nss_n,
	input  wire logic        spi_sck,
	input  wire logic        spi_mosi,
	output logic             spi_miso,
	input  wire logic        modem_wr,
	input  wire logic [7:0]  modem_addr,
	input  wire logic [7:0]  modem_wdata,
	output logic [7:0]       modem_rdata,
	output smc_pkg::smc_cfg_t cfg,
	output logic [12:0]      chips_per_symbol,
	output logic [3:0]       coded_bits,
	output logic             code_rate_in_header,
	output logic [18:0]      channel_bw_hz,
	output logic [18:0]      symbol_rate_hz,
	output logic [7:0]       detection_tuning_a,
	output logic [7:0]       detection_threshold_b
);
	localparam int AW = $clog2(FIFO_DEPTH);
	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	// true when a field value lies inside its legal window
	function automatic logic in_window(input logic [3:0] v,
			input logic [3:0] lo, input logic [3:0] hi);
		in_window = (v >= lo) && (v <= hi);
	endfunction
	// ----------------------------------------------------------------
	// spi port
	// ----------------------------------------------------------------
	smc_pkg::smc_req_t req;
	logic [7:0]        rd_data;
	smc_spi_slave u_spi (
		.clk_sys   (clk_sys),
		.rst       (rst),
		.spi_nss_n (spi_nss_n),
		.spi_sck   (spi_sck),
		.spi_mosi  (spi_mosi),
		.spi_miso  (spi_miso),
		.rd_data   (rd_data),
		.req       (req)
	);
	// ----------------------------------------------------------------
	// storage
	// ----------------------------------------------------------------
	logic [7:0] op_mode;
	logic [7:0] fifo_ptr;
	logic [7:0] fsk_regs [0:127];
	logic [7:0] fifo_mem [0:FIFO_DEPTH-1];
	logic [3:0] bw_code;
	logic [2:0] code_rate;
	logic       implicit_hdr;
	logic [3:0] spread_factor;
	// ----------------------------------------------------------------
	// decode
	// ----------------------------------------------------------------
	wire spread   = op_mode[smc_pkg::OPM_SPREAD_BIT];
	wire in_sleep = op_mode[2:0] == smc_pkg::MODE_SLEEP;
	wire wr_opm   = req.wr & (req.addr == smc_pkg::ADDR_OP_MODE);
	wire wr_sp    = req.wr & spread & (req.addr != smc_pkg::ADDR_OP_MODE);
	wire wr_fsk   = req.wr & ~spread & (req.addr != smc_pkg::ADDR_OP_MODE);
	wire wr_fifo  = wr_sp & (req.addr == smc_pkg::ADDR_FIFO);
	wire wr_ptr   = wr_sp & (req.addr == smc_pkg::ADDR_FIFO_PTR);
	wire wr_cfg1  = wr_sp & (req.addr == smc_pkg::ADDR_MODEM_CFG1);
	wire wr_cfg2  = wr_sp & (req.addr == smc_pkg::ADDR_MODEM_CFG2);
	wire wr_tna   = wr_sp & (req.addr == smc_pkg::ADDR_DET_TUNE_A);
	wire wr_thb   = wr_sp & (req.addr == smc_pkg::ADDR_DET_THR_B);
	wire rd_fifo  = req.rd & spread & (req.addr == smc_pkg::ADDR_FIFO);
	wire [3:0] new_bw = req.data[7:4];
	wire [2:0] new_cr = req.data[3:1];
	wire [3:0] new_sf = req.data[7:4];
	wire bw_ok = in_window(new_bw, 4'h0, smc_pkg::BW_MAX);
	wire cr_ok = in_window({1'b0, new_cr}, {1'b0, smc_pkg::CR_MIN},
		{1'b0, smc_pkg::CR_MAX});
	wire sf_ok = in_window(new_sf, smc_pkg::SF_MIN, smc_pkg::SF_MAX);
	wire [AW-1:0] ptr       = fifo_ptr[AW-1:0];
	wire [AW-1:0] modem_idx = modem_addr[AW-1:0];
	wire [7:0]    buf_rd    = fifo_mem[ptr];
	wire [7:0]    modem_rd  = fifo_mem[modem_idx];
	wire [7:0]    fsk_rd    = fsk_regs[req.addr];
	logic [7:0] spread_rd;
	always_comb begin
		case (req.addr)
			smc_pkg::ADDR_FIFO:       spread_rd = buf_rd;
			smc_pkg::ADDR_OP_MODE:    spread_rd = op_mode;
			smc_pkg::ADDR_FIFO_PTR:   spread_rd = fifo_ptr;
			smc_pkg::ADDR_MODEM_CFG1:
				spread_rd = {bw_code, code_rate, implicit_hdr};
			smc_pkg::ADDR_MODEM_CFG2: spread_rd = {spread_factor, 4'h0};
			smc_pkg::ADDR_DET_TUNE_A: spread_rd = detection_tuning_a;
			smc_pkg::ADDR_DET_THR_B:  spread_rd = detection_threshold_b;
			default:                  spread_rd = 8'h00;
		endcase
	end
	assign rd_data = (req.addr == smc_pkg::ADDR_OP_MODE) ? op_mode :
		spread ? spread_rd : fsk_rd; // R2
	// ----------------------------------------------------------------
	// mode register
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			op_mode <= smc_pkg::RST_OP_MODE;
		end else if (wr_opm) begin
			op_mode[6:0] <= req.data[6:0];
			if (in_sleep) begin
				op_mode[7] <= req.data[7]; // R1
			end
		end
	end
	always_ff @(posedge clk_sys) begin
		if (wr_fsk) begin
			fsk_regs[req.addr] <= req.data; // R2
		end
	end
	// ----------------------------------------------------------------
	// spread modem registers
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			bw_code               <= smc_pkg::RST_BW_CODE;
			code_rate             <= smc_pkg::RST_CODE_RATE;
			implicit_hdr          <= 1'b0;
			spread_factor         <= smc_pkg::RST_SPREAD;
			detection_tuning_a    <= smc_pkg::RST_DET_TUNE_A;
			detection_threshold_b <= smc_pkg::RST_DET_THR_B;
		end else begin
			if (wr_cfg1) begin
				implicit_hdr <= req.data[0];
				if (bw_ok) begin
					bw_code <= new_bw; // R11
				end
				if (cr_ok) begin
					code_rate <= new_cr; // R9
				end
			end
			if (wr_cfg2 && sf_ok) begin
				spread_factor <= new_sf; // R4
			end
			if (wr_tna) begin
				detection_tuning_a <= req.data; // R15
			end
			if (wr_thb) begin
				detection_threshold_b <= req.data; // R15
			end
		end
	end
	// ----------------------------------------------------------------
	// data buffer
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			fifo_ptr <= 8'h00;
		end else if (wr_ptr) begin
			fifo_ptr <= req.data;
		end else if (wr_fifo || rd_fifo) begin
			fifo_ptr <= fifo_ptr + 8'h01; // R3
		end
	end
	always_ff @(posedge clk_sys) begin
		if (wr_fifo) begin
			fifo_mem[ptr] <= req.data; // R3
		end else if (modem_wr) begin
			fifo_mem[modem_idx] <= modem_wdata;
		end
	end
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			modem_rdata <= 8'h00;
		end else begin
			modem_rdata <= modem_rd; // R3
		end
	end
	// ----------------------------------------------------------------
	// derived link parameters
	// ----------------------------------------------------------------
	wire [18:0] bw_now = smc_pkg::bw_hz(bw_code);
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			cfg                 <= '0;
			chips_per_symbol    <= 13'h0000;
			coded_bits          <= 4'h0;
			code_rate_in_header <= 1'b0;
			channel_bw_hz       <= 19'h00000;
			symbol_rate_hz      <= 19'h00000;
		end else begin
			cfg.spread_mode   <= spread;
			cfg.mode          <= op_mode[2:0];
			cfg.bw_code       <= bw_code;
			cfg.code_rate     <= code_rate;
			cfg.implicit_hdr  <= implicit_hdr;
			cfg.spread_factor <= spread_factor;
			chips_per_symbol  <= 13'h0001 << spread_factor; // R4
			coded_bits        <= smc_pkg::DATA_BITS + {1'b0, code_rate}; // R9
			code_rate_in_header <= ~implicit_hdr; // R10
			channel_bw_hz     <= bw_now; // R12
			symbol_rate_hz    <= bw_now >> spread_factor; // R14
		end
	end
endmodule // smc_modem_cfg
`default_nettype wire

/* smc_modem_cfg_properties.sv */
// timing and value properties of the spread modem configuration block
`timescale 1ns/1ps
`default_nettype none
module smc_modem_cfg_properties #(
	parameter int FIFO_DEPTH = 64
) (
	input  wire logic              clk_sys,
	input  wire logic              rst,
	input  wire logic              spi_nss_n,
	input  wire logic              spi_miso,
	input  wire smc_pkg::smc_cfg_t cfg,
	input  wire logic [12:0]       chips_per_symbol,
	input  wire logic [3:0]        coded_bits,
	input  wire logic              code_rate_in_header,
	input  wire logic [18:0]       channel_bw_hz,
	input  wire logic [18:0]       symbol_rate_hz
);
	// ------------------------------------------------
	// properties
	// ------------------------------------------------
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);
	sequence s_idle;
		spi_nss_n [*8];
	endsequence
	property p_chips;
		!$past(rst) |-> chips_per_symbol == (13'h1 << cfg.spread_factor);
	endproperty
	property p_sf_rng;
		!$past(rst) |-> cfg.spread_factor inside {[4'h6:4'hC]};
	endproperty
	property p_coded;
		!$past(rst) |-> coded_bits == 4'h4 + cfg.code_rate;
	endproperty
	property p_cr_rng;
		!$past(rst) |-> cfg.code_rate inside {[3'h1:3'h4]};
	endproperty
	property p_hdr;
		!$past(rst) |-> code_rate_in_header == !cfg.implicit_hdr;
	endproperty
	property p_bw_rng;
		cfg.bw_code <= 4'h9;
	endproperty
	property p_sym;
		!$past(rst) |-> symbol_rate_hz ==
			(channel_bw_hz >> cfg.spread_factor);
	endproperty
	property p_sel;
		!$past(rst) && $changed(cfg.spread_mode) |-> $past(cfg.mode) == 3'h0;
	endproperty
	property p_idle;
		s_idle |=> $stable(spi_miso);
	endproperty
	a_chips: assert property (p_chips)
		else $error("chips per symbol wrong");
	a_sf_rng: assert property (p_sf_rng)
		else $error("spread factor out of range");
	a_coded: assert property (p_coded)
		else $error("coded bits wrong");
	a_cr_rng: assert property (p_cr_rng)
		else $error("code rate out of range");
	a_hdr: assert property (p_hdr)
		else $error("header code rate flag wrong");
	a_bw_rng: assert property (p_bw_rng)
		else $error("bandwidth code out of range");
	a_sym: assert property (p_sym)
		else $error("symbol rate wrong");
	a_sel: assert property (p_sel)
		else $error("modem select changed outside sleep");
	a_idle: assert property (p_idle)
		else $error("miso moved while deselected");
endmodule // smc_modem_cfg_properties
bind smc_modem_cfg smc_modem_cfg_properties #(.FIFO_DEPTH(FIFO_DEPTH)) u_props (
	.clk_sys(clk_sys), .rst(rst), .spi_nss_n(spi_nss_n), .spi_miso(spi_miso),
	.cfg(cfg), .chips_per_symbol(chips_per_symbol), .coded_bits(coded_bits),
	.code_rate_in_header(code_rate_in_header),
	.channel_bw_hz(channel_bw_hz), .symbol_rate_hz(symbol_rate_hz)
);
`default_nettype wire

/* smc_pkg.sv */
// shared constants and types of the spread modem configuration block
`default_nettype none
package smc_pkg;
	// ----------------------------------------------------------------
	// register addresses
	// ----------------------------------------------------------------
	localparam logic [6:0] ADDR_FIFO       = 7'h00;
	localparam logic [6:0] ADDR_OP_MODE    = 7'h01;
	localparam logic [6:0] ADDR_FIFO_PTR   = 7'h0D;
	localparam logic [6:0] ADDR_MODEM_CFG1 = 7'h1D;
	localparam logic [6:0] ADDR_MODEM_CFG2 = 7'h1E;
	localparam logic [6:0] ADDR_DET_TUNE_A = 7'h31;
	localparam logic [6:0] ADDR_DET_THR_B  = 7'h37;
	// ----------------------------------------------------------------
	// field positions and reset values
	// ----------------------------------------------------------------
	localparam int         OPM_SPREAD_BIT  = 7;
	localparam logic [2:0] MODE_SLEEP      = 3'h0;
	localparam logic [7:0] RST_OP_MODE     = 8'h00;
	localparam logic [3:0] RST_BW_CODE     = 4'h7;
	localparam logic [2:0] RST_CODE_RATE   = 3'h1;
	localparam logic [3:0] RST_SPREAD      = 4'h7;
	localparam logic [7:0] RST_DET_TUNE_A  = 8'h03;
	localparam logic [7:0] RST_DET_THR_B   = 8'h0A;
	localparam logic [3:0] SF_MIN          = 4'h6;
	localparam logic [3:0] SF_MAX          = 4'hC;
	localparam logic [2:0] CR_MIN          = 3'h1;
	localparam logic [2:0] CR_MAX          = 3'h4;
	localparam logic [3:0] BW_MAX          = 4'h9;
	localparam logic [3:0] DATA_BITS       = 4'h4;
	// ----------------------------------------------------------------
	// types
	// ----------------------------------------------------------------
	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [6:0] addr;
		logic [7:0] data;
	} smc_req_t;
	typedef struct packed {
		logic       spread_mode;
		logic [2:0] mode;
		logic [3:0] bw_code;
		logic [2:0] code_rate;
		logic       implicit_hdr;
		logic [3:0] spread_factor;
	} smc_cfg_t;
	// channel bandwidth in hertz per bandwidth code
	function automatic logic [18:0] bw_hz(input logic [3:0] code);
		case (code)
			4'h0:    bw_hz = 19'h01E78;
			4'h1:    bw_hz = 19'h028A0;
			4'h2:    bw_hz = 19'h03CF0;
			4'h3:    bw_hz = 19'h05140;
			4'h4:    bw_hz = 19'h079E0;
			4'h5:    bw_hz = 19'h0A2E4;
			4'h6:    bw_hz = 19'h0F424;
			4'h7:    bw_hz = 19'h1E848;
			4'h8:    bw_hz = 19'h3D090;
			default: bw_hz = 19'h7A120;
		endcase
	endfunction
endpackage
`default_nettype wire

/* smc_spi_slave.sv */
// spi register port slave with pin synchronisers
`timescale 1ns/1ps
`default_nettype none
module smc_spi_slave (
	input  wire logic             clk_sys,
	input  wire logic             rst,
	input  wire logic             spi_nss_n,
	input  wire logic             spi_sck,
	input  wire logic             spi_mosi,
	output logic                  spi_miso,
	input  wire logic [7:0]       rd_data,
	output smc_pkg::smc_req_t     req
);
	// ----------------------------------------------------------------
	// synchronisers
	// ----------------------------------------------------------------
	logic [2:0] sync_a;
	logic [2:0] sync_b;
	logic       sck_d;
	always_ff @(posedge clk_sys) begin
		sync_a <= {spi_mosi, spi_sck, spi_nss_n};
		sync_b <= sync_a;
		sck_d  <= sync_b[1];
	end
	wire nss_n    = sync_b[0];
	wire sck_rise = sync_b[1] & ~sck_d & ~nss_n;
	wire sck_fall = ~sync_b[1] & sck_d & ~nss_n;
	// ----------------------------------------------------------------
	// byte framing
	// ----------------------------------------------------------------
	logic [2:0] bit_cnt;
	logic [7:0] rx;
	logic [7:0] tx;
	logic       have_addr;
	logic       write_acc;
	logic [6:0] addr;
	wire  [7:0] rx_byte  = {rx[6:0], sync_b[2]};
	wire        byte_end = sck_rise & (bit_cnt == 3'h7);
	wire        load_tx  = sck_fall & have_addr & (bit_cnt == 3'h0);
	wire        burst_inc = addr != smc_pkg::ADDR_FIFO;
	always_ff @(posedge clk_sys) begin
		if (rst | nss_n) begin
			bit_cnt   <= 3'h0;
			have_addr <= 1'b0;
			write_acc <= 1'b0;
			addr      <= 7'h00;
		end else if (sck_rise) begin
			bit_cnt <= bit_cnt + 3'h1;
			rx      <= rx_byte;
			if (byte_end && !have_addr) begin
				have_addr <= 1'b1;
				write_acc <= rx_byte[7];
				addr      <= rx_byte[6:0];
			end else if (byte_end && burst_inc) begin
				addr <= addr + 7'h01;
			end
		end
	end
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			req      <= '0;
			tx       <= 8'h00;
			spi_miso <= 1'b0;
		end else begin
			req.wr   <= byte_end & have_addr & write_acc; // R3
			req.rd   <= load_tx & ~write_acc;
			req.addr <= addr;
			req.data <= rx_byte;
			if (load_tx) begin
				tx       <= {rd_data[6:0], 1'b0};
				spi_miso <= rd_data[7];
			end else if (sck_fall) begin
				tx       <= {tx[6:0], 1'b0};
				spi_miso <= tx[7];
			end
		end
	end
endmodule // smc_spi_slave
`default_nettype wire

/* tb_spread_modem_link_config.sv */
// self-checking bench for the spread modem configuration block
`timescale 1ns/1ps
`default_nettype none
module tb_spread_modem_link_config;
	logic              clk_sys = 1'b0;
	logic              rst = 1'b1;
	logic              spi_nss_n, spi_sck, spi_mosi, spi_miso, hdr;
	logic              modem_wr = 1'b0;
	logic [7:0]        modem_addr = 8'h00, modem_wdata = 8'h00;
	logic [7:0]        modem_rdata, tune_a, thr_b, q, d;
	logic [7:0]        buf_q [$];
	logic [12:0]       chips;
	logic [3:0]        coded;
	logic [18:0]       bw_hz, sym_hz;
	smc_pkg::smc_cfg_t cfg;
	int                n_mismatch = 0, checked = 0, cyc = 0, sp = 0, md = 0;
	int                im = 0, bw = smc_pkg::RST_BW_CODE;
	int                cr = smc_pkg::RST_CODE_RATE, sf = smc_pkg::RST_SPREAD;
	int                ea = smc_pkg::RST_DET_TUNE_A, eb = smc_pkg::RST_DET_THR_B;
	int                tbl [10] = '{7800, 10400, 15600, 20800, 31200, 41700,
		62500, 125000, 250000, 500000};
	always #20 clk_sys = ~clk_sys;
	smc_host_model host (.clk_sys(clk_sys), .spi_nss_n(spi_nss_n),
		.spi_sck(spi_sck), .spi_mosi(spi_mosi), .spi_miso(spi_miso));
	smc_modem_cfg uut (.clk_sys(clk_sys), .rst(rst), .spi_nss_n(spi_nss_n),
		.spi_sck(spi_sck), .spi_mosi(spi_mosi), .spi_miso(spi_miso),
		.modem_wr(modem_wr), .modem_addr(modem_addr),
		.modem_wdata(modem_wdata), .modem_rdata(modem_rdata), .cfg(cfg),
		.chips_per_symbol(chips), .coded_bits(coded),
		.code_rate_in_header(hdr), .channel_bw_hz(bw_hz),
		.symbol_rate_hz(sym_hz), .detection_tuning_a(tune_a),
		.detection_threshold_b(thr_b));
	// ------------------------------------------------
	// checking, model and bus tasks
	// ------------------------------------------------
	task automatic close_out();
		$display("checked %0d mismatches %0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 60000) begin
			n_mismatch++;
			close_out();
		end
	end
	task automatic cmp(input string n, input logic [18:0] e,
			input logic [18:0] g);
		checked++;
		if (g !== e) begin
			n_mismatch++;
			$display("unexpected %s exp %h got %h", n, e, g);
		end
	endtask
	task automatic wr(input logic [6:0] a, input logic [7:0] v);
		logic [7:0] r;
		host.xfer({1'b1, a}, v, r);
		if (a == 7'h01) begin
			if (md == 0) sp = v[7];
			md = v[2:0];
		end else if (sp == 1 && a == 7'h1D) begin
			if (v[7:4] <= 4'h9) bw = v[7:4];
			if (v[3:1] inside {[3'h1:3'h4]}) cr = v[3:1];
			im = v[0];
		end else if (sp == 1 && a == 7'h1E && v[7:4] inside {[4'h6:4'hC]})
			sf = v[7:4];
		else if (sp == 1 && a == 7'h31) ea = v;
		else if (sp == 1 && a == 7'h37) eb = v;
	endtask
	task automatic chk_cfg();
		cmp("spread_mode", 19'(sp), 19'(cfg.spread_mode));
		cmp("mode", 19'(md), 19'(cfg.mode));
		cmp("bw_code", 19'(bw), 19'(cfg.bw_code));
		cmp("code_rate", 19'(cr), 19'(cfg.code_rate));
		cmp("implicit", 19'(im), 19'(cfg.implicit_hdr));
		cmp("spread_factor", 19'(sf), 19'(cfg.spread_factor));
		cmp("chips", 19'(1 << sf), 19'(chips));
		cmp("coded_bits", 19'(4 + cr), 19'(coded));
		cmp("hdr_rate", 19'(im == 0), 19'(hdr));
		cmp("bw_hz", 19'(tbl[bw]), bw_hz);
		cmp("sym_hz", 19'(tbl[bw] >> sf), sym_hz);
		cmp("tune_a", 19'(ea), 19'(tune_a));
		cmp("thr_b", 19'(eb), 19'(thr_b));
	endtask
	// ------------------------------------------------
	// main sequence
	// ------------------------------------------------
	initial begin
		void'($urandom(84957));
		repeat (20) @(posedge clk_sys);
		#1 rst = 1'b0;
		repeat (4) @(posedge clk_sys);
		chk_cfg();
		wr(7'h1E, 8'h60);
		chk_cfg();
		wr(7'h01, 8'h83);
		wr(7'h01, 8'h03);
		chk_cfg();
		wr(7'h01, 8'h80);
		chk_cfg();
		for (int i = 0; i < 16; i++) begin
			wr(7'h1E, 8'(i << 4));
			chk_cfg();
			host.xfer(8'h1E, 8'h00, q);
			cmp("sf_rd", 19'(sf << 4), 19'(q));
		end
		for (int i = 0; i < 24; i++) begin
			d = 8'($urandom);
			if (i >= 12) d[7] = 1'b0;
			wr(7'h1D, d);
			chk_cfg();
		end
		wr(7'h1E, 8'h60);
		wr(7'h1D, 8'h73);
		host.xfer(8'h31, 8'h00, q);
		wr(7'h31, {q[7:3], 3'b101});
		wr(7'h37, 8'h0C);
		host.xfer(8'h31, 8'h00, q);
		cmp("tune_a_rd", 19'(ea), 19'(q));
		host.xfer(8'h37, 8'h00, q);
		cmp("thr_b_rd", 19'(eb), 19'(q));
		chk_cfg();
		host.xfer(8'h7F, 8'h00, q);
		cmp("unmapped", 19'h00000, 19'(q));
		d = 8'($urandom);
		buf_q.push_back(d);
		@(posedge clk_sys) #1 modem_addr = 8'h05;
		modem_wdata = d;
		modem_wr = 1'b1;
		@(posedge clk_sys) #1 modem_wr = 1'b0;
		wr(7'h0D, 8'h05);
		host.xfer(8'h00, 8'h00, q);
		cmp("buf_spi_rd", 19'(buf_q.pop_front()), 19'(q));
		d = 8'($urandom);
		buf_q.push_back(d);
		wr(7'h0D, 8'h06);
		wr(7'h00, d);
		@(posedge clk_sys) #1 modem_addr = 8'h06;
		d = buf_q.pop_front();
		@(posedge clk_sys) #1 cmp("buf_modem_rd", 19'(d), 19'(modem_rdata));
		close_out();
	end
endmodule // tb_spread_modem_link_config
`default_nettype wire
